//--- logic/i2css_defs.svh
// constants for the slave status flag block
//
// Contract
// RL1: stop after addressed start sets bit 10
// RL2: bits 9:8 report general call type
// RL3: any general call sets bit 7
// RL4: config bit 8 write clears bit 7
// RL5: general call reset restores register defaults
// RL6: hardware general call pushes second byte
// RL7: bit 6 follows slave busy level
// RL8: no data for master sets bit 5
// RL9: receive overflow sets bit 4
// RL10: received data sets bit 3
// RL11: end of transmission sets bit 2
// RL12: transmit underflow sets bit 1
// RL13: bit 0 high while transmit not full
// RL14: read returns flags before read clears
// RL15: start plus address match sets bit 14
// RL16: repeated start plus match sets bit 13; the code sets it only while already addressed
// RL17: bits 12:11 report matched identifier
`ifndef I2CSS_DEFS_SVH
`define I2CSS_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define I2CSS_OFF_STATUS 8'h04
`define I2CSS_OFF_RX 8'h08
`define I2CSS_OFF_TX 8'h0C
`define I2CSS_OFF_ALT 8'h28
`define I2CSS_OFF_CFG 8'h2C
`define I2CSS_OFF_IRQ_STAT 8'h40
`define I2CSS_OFF_IRQ_MASK 8'h44

// ----------------------------------------
// status and config bit positions
// ----------------------------------------
`define I2CSS_B_START 14
`define I2CSS_B_RSTART 13
`define I2CSS_B_ID_HI 12
`define I2CSS_B_ID_LO 11
`define I2CSS_B_STOP 10
`define I2CSS_B_GC_HI 9
`define I2CSS_B_GC_LO 8
`define I2CSS_B_GC 7
`define I2CSS_B_BUSY 6
`define I2CSS_B_NOACK 5
`define I2CSS_B_OVF 4
`define I2CSS_B_RX 3
`define I2CSS_B_TX 2
`define I2CSS_B_UND 1
`define I2CSS_B_NF 0
`define I2CSS_B_CFG_GC_CLR 8

// ----------------------------------------
// widths, reset values, counts
// ----------------------------------------
`define I2CSS_FLAG_W 11
`define I2CSS_EVT_MASK 11'h4BE
`define I2CSS_RST_STATUS 32'h0000_0001
`define I2CSS_RST_ALT 8'h00
`define I2CSS_RST_MASK 11'h000
`define I2CSS_TX_DEPTH 2

`endif

//--- logic/i2css_pkg.sv
// types for the slave status flag block
package i2css_pkg;

    typedef enum logic [1:0] {
        I2CSS_GC_NONE = 2'h0,
        I2CSS_GC_RST_PROG = 2'h1,
        I2CSS_GC_PROG = 2'h2,
        I2CSS_GC_ALT = 2'h3
    } i2css_gc_t;

    typedef enum logic [2:0] {
        I2CSS_ST_IDLE = 3'h1,
        I2CSS_ST_ADDR = 3'h2,
        I2CSS_ST_RADDR = 3'h4
    } i2css_state_t;

endpackage

//--- logic/i2css_status.sv
// slave channel status flags with register port and interrupt
`timescale 1ns/1ns
`include "i2css_defs.svh"
module i2css_status
    import i2css_pkg::*;
#(
    parameter int TX_DEPTH = `I2CSS_TX_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // slave engine events
    input wire logic ev_start_match,
    input wire logic ev_rstart_match,
    input wire logic [1:0] match_id,
    input wire logic ev_stop,
    input wire logic ev_gc,
    input wire logic [1:0] gc_type,
    input wire logic ev_gc_byte,
    input wire logic [7:0] gc_byte,
    input wire logic slave_busy,
    input wire logic ev_no_data,
    input wire logic ev_rx_overflow,
    input wire logic ev_rx_data,
    input wire logic rx_flush,
    input wire logic [7:0] rx_data,
    input wire logic ev_tx_done,
    input wire logic ev_tx_underflow,
    input wire logic ev_tx_taken,
    // fifo and controller side
    output logic rx_pop,
    output logic rx_push,
    output logic [7:0] rx_push_data,
    output logic tx_push,
    output logic [7:0] tx_push_data,
    output logic [7:0] gc_alt_id,
    output logic ctrl_soft_rst,
    output logic irq
);
    localparam int CW = $clog2(TX_DEPTH + 1);
    localparam logic [CW-1:0] TX_FULL = CW'(TX_DEPTH);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    generate
        if (TX_DEPTH < 1) begin : g_chk
            $error("i2css_status needs TX_DEPTH of one or more");
        end
    endgenerate

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic stat_rd;
    logic stat_wr;
    logic rx_rd;
    logic tx_wr;
    logic alt_wr;
    logic cfg_wr;
    logic irqs_wr;
    logic irqm_wr;
    logic gc_clr;
    logic soft_rst;

    assign stat_rd = reg_rd && hit(reg_addr, `I2CSS_OFF_STATUS);
    assign stat_wr = reg_wr && hit(reg_addr, `I2CSS_OFF_STATUS);
    assign rx_rd = reg_rd && hit(reg_addr, `I2CSS_OFF_RX);
    assign tx_wr = reg_wr && hit(reg_addr, `I2CSS_OFF_TX);
    assign alt_wr = reg_wr && hit(reg_addr, `I2CSS_OFF_ALT);
    assign cfg_wr = reg_wr && hit(reg_addr, `I2CSS_OFF_CFG);
    assign irqs_wr = reg_wr && hit(reg_addr, `I2CSS_OFF_IRQ_STAT);
    assign irqm_wr = reg_wr && hit(reg_addr, `I2CSS_OFF_IRQ_MASK);

    assign gc_clr = cfg_wr && reg_wdata[`I2CSS_B_CFG_GC_CLR]; // RL4
    assign soft_rst = ev_gc && (gc_type == I2CSS_GC_RST_PROG); // RL5

    // ----------------------------------------
    // addressed state machine
    // ----------------------------------------
    i2css_state_t state_ff;
    i2css_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            I2CSS_ST_IDLE: begin
                if (ev_start_match) begin
                    nxt_state = I2CSS_ST_ADDR;
                end
            end
            I2CSS_ST_ADDR, I2CSS_ST_RADDR: begin
                if (ev_stop || soft_rst) begin
                    nxt_state = I2CSS_ST_IDLE; // RL15
                end else if (ev_rstart_match) begin
                    nxt_state = I2CSS_ST_RADDR;
                end
            end
            default: begin
                nxt_state = I2CSS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= I2CSS_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    logic addressed;
    assign addressed = (state_ff != I2CSS_ST_IDLE); // RL15

    // ----------------------------------------
    // repeated start and matched identifier
    // ----------------------------------------
    logic rstart_ff;
    logic [1:0] id_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstart_ff <= 1'b0;
        end else if (ev_rstart_match && addressed) begin
            rstart_ff <= 1'b1; // RL16
        end else if (ev_stop || stat_rd || soft_rst) begin
            rstart_ff <= 1'b0; // RL16
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            id_ff <= 2'h0;
        end else if (ev_start_match || ev_rstart_match) begin
            id_ff <= match_id; // RL17
        end else if (soft_rst) begin
            id_ff <= 2'h0;
        end
    end

    // ----------------------------------------
    // general call type
    // ----------------------------------------
    logic [1:0] gc_type_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gc_type_ff <= I2CSS_GC_NONE;
        end else if (ev_gc) begin
            gc_type_ff <= gc_type; // RL2
        end else if (gc_clr) begin
            gc_type_ff <= I2CSS_GC_NONE;
        end
    end

    // ----------------------------------------
    // sticky status flags
    // ----------------------------------------
    logic [`I2CSS_FLAG_W-1:0] ev_set;
    logic [`I2CSS_FLAG_W-1:0] flag_clr;
    logic [`I2CSS_FLAG_W-1:0] flags;

    always_comb begin
        ev_set = '0;
        ev_set[`I2CSS_B_STOP] = ev_stop && addressed; // RL1
        ev_set[`I2CSS_B_GC] = ev_gc; // RL3
        ev_set[`I2CSS_B_NOACK] = ev_no_data; // RL8
        ev_set[`I2CSS_B_OVF] = ev_rx_overflow; // RL9
        ev_set[`I2CSS_B_RX] = ev_rx_data; // RL10
        ev_set[`I2CSS_B_TX] = ev_tx_done; // RL11
        ev_set[`I2CSS_B_UND] = ev_tx_underflow; // RL12
    end

    // clears take effect after the read data is captured
    always_comb begin
        flag_clr = '0;
        flag_clr[`I2CSS_B_STOP] = stat_rd || soft_rst; // RL1 RL14
        flag_clr[`I2CSS_B_GC] = gc_clr; // RL4
        flag_clr[`I2CSS_B_NOACK] = stat_rd || soft_rst; // RL8 RL14
        flag_clr[`I2CSS_B_OVF] = stat_rd || soft_rst; // RL9 RL14
        flag_clr[`I2CSS_B_RX] = rx_rd || rx_flush || soft_rst; // RL10
        flag_clr[`I2CSS_B_TX] = tx_wr || soft_rst; // RL11
        flag_clr[`I2CSS_B_UND] = stat_wr || soft_rst; // RL12
    end

    i2css_sticky #(
        .W(`I2CSS_FLAG_W)
    ) u_flags (
        .clk(clk),
        .rst_b(rst_b),
        .set(ev_set),
        .clr(flag_clr),
        .q(flags)
    );

    // ----------------------------------------
    // transmit fill count
    // ----------------------------------------
    logic [CW-1:0] tx_cnt_ff;
    logic tx_not_full;
    logic tx_inc;
    logic tx_dec;

    assign tx_not_full = (tx_cnt_ff < TX_FULL); // RL13
    assign tx_inc = tx_wr && tx_not_full;
    assign tx_dec = ev_tx_taken && (tx_cnt_ff != '0);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cnt_ff <= '0;
        end else if (soft_rst) begin
            tx_cnt_ff <= '0;
        end else if (tx_inc && !tx_dec) begin
            tx_cnt_ff <= tx_cnt_ff + CNT_ONE; // RL13
        end else if (tx_dec && !tx_inc) begin
            tx_cnt_ff <= tx_cnt_ff - CNT_ONE;
        end
    end

    logic tx_push_ff;
    logic [7:0] tx_data_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_push_ff <= 1'b0;
        end else begin
            tx_push_ff <= tx_inc;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_data_ff <= 8'h00;
        end else if (tx_inc) begin
            tx_data_ff <= reg_wdata[7:0];
        end
    end

    // ----------------------------------------
    // general call byte into receive fifo
    // ----------------------------------------
    logic rx_push_ff;
    logic [7:0] rx_push_data_ff;
    logic gc_push;

    // address programming calls never reach the fifo
    assign gc_push = ev_gc_byte && (gc_type_ff == I2CSS_GC_ALT); // RL6

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_push_ff <= 1'b0;
        end else begin
            rx_push_ff <= gc_push; // RL6
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_push_data_ff <= 8'h00;
        end else if (gc_push) begin
            rx_push_data_ff <= gc_byte; // RL6
        end
    end

    // ----------------------------------------
    // alternative id and soft reset pulse
    // ----------------------------------------
    logic [7:0] alt_ff;
    logic soft_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alt_ff <= `I2CSS_RST_ALT;
        end else if (soft_rst) begin
            alt_ff <= `I2CSS_RST_ALT; // RL5
        end else if (alt_wr) begin
            alt_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_ff <= 1'b0;
        end else begin
            soft_ff <= soft_rst; // RL5
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [`I2CSS_FLAG_W-1:0] irq_clr;
    logic [`I2CSS_FLAG_W-1:0] irq_flags;
    logic [`I2CSS_FLAG_W-1:0] mask_ff;

    always_comb begin
        irq_clr = '0;
        if (soft_rst) begin
            irq_clr = `I2CSS_EVT_MASK;
        end else if (irqs_wr) begin
            irq_clr = reg_wdata[`I2CSS_FLAG_W-1:0] & `I2CSS_EVT_MASK;
        end
    end

    i2css_sticky #(
        .W(`I2CSS_FLAG_W)
    ) u_irq (
        .clk(clk),
        .rst_b(rst_b),
        .set(ev_set),
        .clr(irq_clr),
        .q(irq_flags)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_ff <= `I2CSS_RST_MASK;
        end else if (soft_rst) begin
            mask_ff <= `I2CSS_RST_MASK; // RL5
        end else if (irqm_wr) begin
            mask_ff <= reg_wdata[`I2CSS_FLAG_W-1:0] & `I2CSS_EVT_MASK;
        end
    end

    // ----------------------------------------
    // status word and read port
    // ----------------------------------------
    logic [31:0] status;

    always_comb begin
        status = '0;
        status[`I2CSS_B_START] = addressed; // RL15
        status[`I2CSS_B_RSTART] = rstart_ff; // RL16
        status[`I2CSS_B_ID_HI:`I2CSS_B_ID_LO] = id_ff; // RL17
        status[`I2CSS_B_STOP] = flags[`I2CSS_B_STOP];
        status[`I2CSS_B_GC_HI:`I2CSS_B_GC_LO] = gc_type_ff; // RL2
        status[`I2CSS_B_GC] = flags[`I2CSS_B_GC];
        status[`I2CSS_B_BUSY] = slave_busy; // RL7
        status[`I2CSS_B_NOACK] = flags[`I2CSS_B_NOACK];
        status[`I2CSS_B_OVF] = flags[`I2CSS_B_OVF];
        status[`I2CSS_B_RX] = flags[`I2CSS_B_RX];
        status[`I2CSS_B_TX] = flags[`I2CSS_B_TX];
        status[`I2CSS_B_UND] = flags[`I2CSS_B_UND];
        status[`I2CSS_B_NF] = tx_not_full; // RL13
    end

    logic [31:0] rd_mux;
    logic [31:0] rdata_ff;

    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            `I2CSS_OFF_STATUS: rd_mux = status; // RL14
            `I2CSS_OFF_RX: rd_mux = {24'h00_0000, rx_data};
            `I2CSS_OFF_ALT: rd_mux = {24'h00_0000, alt_ff};
            `I2CSS_OFF_IRQ_STAT: rd_mux = {21'h0_0000, irq_flags};
            `I2CSS_OFF_IRQ_MASK: rd_mux = {21'h0_0000, mask_ff};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux; // RL14
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    logic irq_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_flags & mask_ff);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = rdata_ff;
    assign rx_pop = rx_rd;
    assign rx_push = rx_push_ff;
    assign rx_push_data = rx_push_data_ff;
    assign tx_push = tx_push_ff;
    assign tx_push_data = tx_data_ff;
    assign gc_alt_id = alt_ff;
    assign ctrl_soft_rst = soft_ff;
    assign irq = irq_ff;
endmodule // i2css_status

//--- logic/i2css_sticky.sv
// bank of sticky flags where a set beats a clear
`timescale 1ns/1ns
module i2css_sticky #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    logic [W-1:0] flag_ff;

    generate
        if (W < 1) begin : g_chk
            $error("i2css_sticky needs W of one or more");
        end
        for (genvar i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    flag_ff[i] <= 1'b0;
                end else if (set[i]) begin
                    flag_ff[i] <= 1'b1;
                end else if (clr[i]) begin
                    flag_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign q = flag_ff;
endmodule // i2css_sticky

//--- test/i2css_master_model.sv
// behavioural bus master producing slave engine events
`timescale 1ns/1ns
module i2css_master_model (
    input wire logic clk,
    output logic [11:0] ev,
    output logic [1:0] match_id,
    output logic [1:0] gc_type,
    output logic [7:0] gc_byte,
    output logic [7:0] rx_data,
    output logic slave_busy
);
    initial begin
        ev = 12'h000;
        match_id = 2'h0;
        gc_type = 2'h0;
        gc_byte = 8'h00;
        rx_data = 8'h00;
        slave_busy = 1'b0;
    end
    // one cycle pulse; qualifiers go stale afterwards
    task automatic fire(input int k, input logic [1:0] t = 2'h0, input logic [7:0] b = 8'h00);
        @(posedge clk);
        ev <= 12'h001 << k;
        match_id <= t;
        gc_type <= t;
        rx_data <= b;
        @(posedge clk);
        ev <= 12'h000;
        match_id <= ~t;
        gc_type <= ~t;
    endtask
    // general call followed at once by its second byte
    task automatic gc_call(input logic [1:0] t, input logic [7:0] b);
        @(posedge clk);
        ev <= 12'h008;
        gc_type <= t;
        @(posedge clk);
        ev <= 12'h010;
        gc_type <= ~t;
        gc_byte <= b;
        @(posedge clk);
        ev <= 12'h000;
        gc_byte <= ~b;
    endtask
    task automatic busy(input logic v);
        @(posedge clk);
        slave_busy <= v;
    endtask
endmodule // i2css_master_model

//--- test/i2css_status_assertions.sv
// port-level assertions for the slave status flag block
`timescale 1ns/1ns
`include "i2css_defs.svh"
module i2css_status_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic ev_stop,
    input wire logic ev_gc,
    input wire logic [1:0] gc_type,
    input wire logic ev_gc_byte,
    input wire logic [7:0] gc_byte,
    input wire logic slave_busy,
    input wire logic ev_no_data,
    input wire logic ev_rx_overflow,
    input wire logic rx_pop,
    input wire logic rx_push,
    input wire logic [7:0] rx_push_data,
    input wire logic tx_push,
    input wire logic [7:0] tx_push_data,
    input wire logic ctrl_soft_rst
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_st_rd;
        reg_rd && reg_addr == `I2CSS_OFF_STATUS;
    endsequence
    sequence s_hw_gc;
        ev_gc && gc_type == 2'h3 ##1 ev_gc_byte;
    endsequence
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    chk_busy_live: assert property (s_st_rd |=> reg_rdata[6] == $past(slave_busy))
        else $error("busy bit differs from busy level");
    chk_rd_clears: assert property ((s_st_rd ##0 !(ev_stop || ev_no_data || ev_rx_overflow))
        ##1 s_st_rd |=> reg_rdata[10] == 1'b0 && reg_rdata[5:4] == 2'b00)
        else $error("read clear flags survived a read");
    chk_gc_report: assert property (ev_gc ##1 !ev_gc && !reg_wr ##1 s_st_rd
        |=> reg_rdata[7] && reg_rdata[9:8] == $past(gc_type, 3))
        else $error("general call not reported");
    chk_gc_push: assert property (s_hw_gc |=> rx_push && rx_push_data == $past(gc_byte))
        else $error("general call byte not pushed");
    chk_push_cause: assert property (rx_push |-> $past(ev_gc_byte))
        else $error("push without general call byte");
    chk_soft_rst: assert property (ev_gc && gc_type == 2'h1 |=> ctrl_soft_rst)
        else $error("general call reset not applied");
    chk_rst_cause: assert property (ctrl_soft_rst |-> $past(ev_gc) && $past(gc_type) == 2'h1)
        else $error("soft reset without cause");
    chk_pop_read: assert property (rx_pop == (reg_rd && reg_addr == `I2CSS_OFF_RX))
        else $error("pop not tied to receive read");
    chk_tx_push: assert property (tx_push |-> $past(reg_wr) && $past(reg_addr) == `I2CSS_OFF_TX
        && tx_push_data == $past(reg_wdata[7:0]))
        else $error("transmit push without write");
endmodule // i2css_status_checker

bind i2css_status i2css_status_checker i_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_stop(ev_stop), .ev_gc(ev_gc), .gc_type(gc_type), .ev_gc_byte(ev_gc_byte),
    .gc_byte(gc_byte), .slave_busy(slave_busy), .ev_no_data(ev_no_data),
    .ev_rx_overflow(ev_rx_overflow), .rx_pop(rx_pop), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .tx_push(tx_push), .tx_push_data(tx_push_data),
    .ctrl_soft_rst(ctrl_soft_rst));

//--- test/test_i2css_status.sv
// self-checking bench for the slave status flag block
`timescale 1ns/1ns
`include "i2css_defs.svh"
module test_i2css_status;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] id_mask = 32'hFFFF_E7FF;
    logic [11:0] ev;
    logic [1:0] match_id, gc_type;
    logic [7:0] gc_byte, rx_data, rx_push_data, tx_push_data, gc_alt_id;
    logic slave_busy, rx_push, tx_push, ctrl_soft_rst, irq;
    int n_mismatch = 0;
    int total_checks = 0;
    always #2 clk = ~clk;
    i2css_master_model i_bus (.clk(clk), .ev(ev), .match_id(match_id), .gc_type(gc_type),
        .gc_byte(gc_byte), .rx_data(rx_data), .slave_busy(slave_busy));
    i2css_status #(.TX_DEPTH(2)) i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ev_start_match(ev[0]), .ev_rstart_match(ev[1]), .match_id(match_id),
        .ev_stop(ev[2]), .ev_gc(ev[3]), .gc_type(gc_type), .ev_gc_byte(ev[4]),
        .gc_byte(gc_byte), .slave_busy(slave_busy), .ev_no_data(ev[5]),
        .ev_rx_overflow(ev[6]), .ev_rx_data(ev[7]), .rx_flush(ev[8]), .rx_data(rx_data),
        .ev_tx_done(ev[9]), .ev_tx_underflow(ev[10]), .ev_tx_taken(ev[11]), .rx_pop(),
        .rx_push(rx_push), .rx_push_data(rx_push_data), .tx_push(tx_push),
        .tx_push_data(tx_push_data), .gc_alt_id(gc_alt_id), .ctrl_soft_rst(ctrl_soft_rst),
        .irq(irq));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & m, e);
    endtask
    task automatic rs(input logic [31:0] e, input logic [31:0] m = '1);
        rchk(`I2CSS_OFF_STATUS, e, m);
    endtask
    // two status reads with no gap
    task automatic rs2(input logic [31:0] e1, input logic [31:0] e2);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= `I2CSS_OFF_STATUS;
        @(posedge clk);
        #1 check(reg_rdata & id_mask, e1);
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & id_mask, e2);
    endtask
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rs(32'h0000_0001);
        rchk(8'hF0, 32'h0000_0000);
        i_bus.fire(0, 2'h2);
        rs(32'h0000_5001);
        i_bus.fire(1, 2'h2);
        rs2(32'h0000_6001, 32'h0000_4001);
        i_bus.fire(2);
        rs2(32'h0000_0401, 32'h0000_0001);
        i_bus.busy(1'b1);
        rs(32'h0000_0041, id_mask);
        i_bus.busy(1'b0);
        rs(32'h0000_0001, id_mask);
        for (int i = 0; i < 2; i++) begin
            i_bus.fire(5 + i);
            rs2(32'h0000_0001 | (32'h0000_0020 >> i), 32'h0000_0001);
        end
        i_bus.fire(7, 2'h0, 8'hA5);
        rs(32'h0000_0009, id_mask);
        rchk(`I2CSS_OFF_RX, 32'h0000_00A5);
        rs(32'h0000_0001, id_mask);
        i_bus.fire(7);
        i_bus.fire(8);
        rs(32'h0000_0001, id_mask);
        i_bus.fire(9);
        rs(32'h0000_0005, id_mask);
        wr(`I2CSS_OFF_TX, 32'h0000_003C);
        #1 check({tx_push, tx_push_data}, 32'h0000_013C);
        rs(32'h0000_0001, id_mask);
        wr(`I2CSS_OFF_TX, 32'h0000_00C3);
        rs(32'h0000_0000, id_mask);
        wr(`I2CSS_OFF_TX, 32'h0000_0055);
        #1 check(32'(tx_push), 32'h0000_0000);
        i_bus.fire(11);
        rs(32'h0000_0001, id_mask);
        i_bus.fire(11);
        i_bus.fire(10);
        rs(32'h0000_0003, id_mask);
        wr(`I2CSS_OFF_STATUS, 32'h0000_0000);
        rs(32'h0000_0001, id_mask);
        for (int t = 0; t < 2; t++) begin
            i_bus.fire(3, t[1:0] | 2'h2);
            rs(32'h0000_0281 | 32'(t << 8), id_mask);
            rs(32'h0000_0281 | 32'(t << 8), id_mask);
            wr(`I2CSS_OFF_CFG, 32'h0000_0100);
            rs(32'h0000_0001, id_mask);
        end
        i_bus.gc_call(2'h3, 8'h5A);
        #1 check({rx_push, rx_push_data}, 32'h0000_015A);
        i_bus.gc_call(2'h2, 8'hC3);
        #1 check(32'(rx_push), 32'h0000_0000);
        wr(`I2CSS_OFF_ALT, 32'h0000_0077);
        rchk(`I2CSS_OFF_ALT, 32'h0000_0077);
        check(32'(gc_alt_id), 32'h0000_0077);
        wr(`I2CSS_OFF_IRQ_MASK, 32'h0000_0010);
        rchk(`I2CSS_OFF_IRQ_MASK, 32'h0000_0010);
        i_bus.fire(6);
        @(posedge clk);
        #1 check(32'(irq), 32'h0000_0001);
        wr(`I2CSS_OFF_IRQ_STAT, 32'h0000_0010);
        @(posedge clk);
        #1 check(32'(irq), 32'h0000_0000);
        i_bus.fire(0, 2'h3);
        i_bus.fire(6);
        i_bus.fire(3, 2'h1);
        #1 check(32'(ctrl_soft_rst), 32'h0000_0001);
        rs(32'h0000_0181);
        check(32'(irq), 32'h0000_0000);
        rchk(`I2CSS_OFF_ALT, 32'h0000_0000);
        rchk(`I2CSS_OFF_IRQ_MASK, 32'h0000_0000);
        i_bus.fire(6);
        repeat (2) @(posedge clk);
        #1 check(32'(irq), 32'h0000_0000);
        conclude();
    end
endmodule // test_i2css_status
